/* rtl/rg_reset_generator.v */
`timescale 1ns/1ps
`include "rg_regs.vh"

// Functional notes
// R1 - Three reset causes are accepted: the reset pin, power-on reset and a software global reset over SPI.
// R2 - The clock-monitor reset asserts at once on pin or power-on reset and releases on the backup reference.
// R3 - The cipher reset asserts only on power-on reset and releases on the system clock.
// R4 - The SPI reset asserts on pin, power-on, software reset or clock loss and releases only with chip select idle.
// R5 - A serial transfer started while the system clock is missing is aborted and flagged as an error.
// R6 - The main reset asserts on pin, power-on or software reset and releases on the system clock.
// R7 - The software reset code is 32 bits held in two separately addressed 16-bit halves.
// R8 - A correct code resets everything except this block, the clock manager and the cipher register.
// R9 - The software reset pulse lasts eight system clock cycles, after which both code halves are cleared.
// R10 - The valid code is 0xF473 in the first half and 0x57A1 in the second half.
// R11 - The host writes the two code halves at their two consecutive addresses.
// R12 - A 3-bit cause register records sources seen since the last access and clears on every access.
// R13 - Cause bit 2 is software reset, bit 1 power-on reset and bit 0 the reset pin.
// R14 - After a power-on reset the pin flag content is not to be relied on.
// R15 - The clock-missing input is high while no valid system clock is supplied and feeds the SPI reset.
// R16 - The software reset fires only when both halves hold their exact codes together.
// R17 - Every reset releases through a two-stage synchroniser in its own release domain.
module rg_reset_generator (
    input wire clock,
    input wire nrst,
    input wire reset_pin_n,
    input wire power_on_reset_n,
    input wire clock_missing,
    input wire backup_tick,
    input wire spi_cs_n,
    input wire reg_wr_en,
    input wire reg_rd_en,
    input wire [`RG_ADDR_W-1:0] reg_addr,
    input wire [`RG_DATA_W-1:0] reg_wdata,
    output reg [`RG_DATA_W-1:0] reg_rdata_q,
    output reg reg_rd_hit_q,
    output reg spi_xfer_error_q,
    output wire clkmon_rst_n,
    output wire cipher_rst_n,
    output wire spi_rst_n,
    output wire main_rst_n
);

// ============================================================
// Address decode
function addr_is;
    input [`RG_ADDR_W-1:0] addr;
    input [`RG_ADDR_W-1:0] target;
    begin
        addr_is = (addr == target);
    end
endfunction

wire soft_rst;
wire wr_ok;
wire wr_lo;
wire wr_hi;
wire cause_access;
wire src_active;
reg [`RG_CAUSE_W-1:0] cause_q;
reg [`RG_CAUSE_W-1:0] cause_d;
reg spi_cs_n_q;

// ============================================================
// Register writes
// A code-half write that arrives while the system clock is missing is
// dropped, so no dummy data reaches the code halves; a cause access still clears.
assign wr_ok = reg_wr_en && !clock_missing; // R5 R15
assign wr_lo = wr_ok && addr_is(reg_addr, `RG_ADDR_CODE_LO); // R11
assign wr_hi = wr_ok && addr_is(reg_addr, `RG_ADDR_CODE_HI); // R11
assign cause_access = (reg_wr_en || reg_rd_en) && addr_is(reg_addr, `RG_ADDR_CAUSE);

// Pin or power-on reset wipes a half-written code.
assign src_active = !reset_pin_n || !power_on_reset_n;

rg_soft_reset u_soft (
    .clock(clock),
    .nrst(nrst),
    .clear(src_active),
    .wr_lo(wr_lo),
    .wr_hi(wr_hi),
    .wdata(reg_wdata),
    .soft_rst(soft_rst)
);

// ============================================================
// Reset outputs
// Assertion is combinational so a reset reaches its consumers
// even when the release clock is stopped; only release waits
// for the synchroniser.
wire [`RG_NUM_RST-1:0] arst_n;
wire [`RG_NUM_RST-1:0] advance;
wire [`RG_NUM_RST-1:0] release_ok;
wire [`RG_NUM_RST-1:0] rst_n_vec;

assign arst_n[`RG_RST_CLKMON] = nrst && reset_pin_n && power_on_reset_n; // R1 R2
assign arst_n[`RG_RST_CIPHER] = nrst && power_on_reset_n; // R3
assign arst_n[`RG_RST_SPI] = nrst && reset_pin_n && power_on_reset_n && !soft_rst && !clock_missing; // R4 R15
assign arst_n[`RG_RST_MAIN] = nrst && reset_pin_n && power_on_reset_n && !soft_rst; // R6 R8

// The clock-monitor reset steps only on the backup reference tick.
assign advance[`RG_RST_CLKMON] = backup_tick; // R2
assign advance[`RG_RST_CIPHER] = 1'b1;
assign advance[`RG_RST_SPI] = 1'b1;
assign advance[`RG_RST_MAIN] = 1'b1;

assign release_ok[`RG_RST_CLKMON] = 1'b1;
assign release_ok[`RG_RST_CIPHER] = 1'b1;
assign release_ok[`RG_RST_SPI] = spi_cs_n; // R4
assign release_ok[`RG_RST_MAIN] = 1'b1;

genvar gi;
generate
    for (gi = 0; gi < `RG_NUM_RST; gi = gi + 1) begin : g_sync
        rg_rst_sync u_sync (
            .clock(clock),
            .arst_n(arst_n[gi]),
            .advance(advance[gi]),
            .release_ok(release_ok[gi]),
            .rst_n_out(rst_n_vec[gi])
        ); // R17
    end
endgenerate

assign clkmon_rst_n = rst_n_vec[`RG_RST_CLKMON];
assign cipher_rst_n = rst_n_vec[`RG_RST_CIPHER];
assign spi_rst_n = rst_n_vec[`RG_RST_SPI];
assign main_rst_n = rst_n_vec[`RG_RST_MAIN];

// ============================================================
// Reset cause register
// A source seen in the same cycle as the clearing access stays
// recorded, so no event is lost to the read.
always @* begin
    cause_d = cause_q;
    if (cause_access) begin
        cause_d = `RG_CAUSE_RESET; // R12
    end
    if (soft_rst) begin
        cause_d[`RG_CAUSE_SOFT] = 1'b1; // R13
    end
    if (!power_on_reset_n) begin
        cause_d[`RG_CAUSE_POR] = 1'b1; // R13
    end
    if (!reset_pin_n) begin
        cause_d[`RG_CAUSE_PIN] = 1'b1; // R13 R14
    end
end

always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        cause_q <= `RG_CAUSE_RESET;
    end else begin
        cause_q <= cause_d; // R12
    end
end

// ============================================================
// Read port and transfer abort
always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        reg_rdata_q <= {`RG_DATA_W{1'b0}};
        reg_rd_hit_q <= 1'b0;
        spi_cs_n_q <= 1'b1;
        spi_xfer_error_q <= 1'b0;
    end else begin
        spi_cs_n_q <= spi_cs_n;
        // A transfer opening while the clock is missing is flagged.
        spi_xfer_error_q <= spi_cs_n_q && !spi_cs_n && clock_missing; // R5
        reg_rd_hit_q <= reg_rd_en && addr_is(reg_addr, `RG_ADDR_CAUSE);
        if (reg_rd_en && addr_is(reg_addr, `RG_ADDR_CAUSE)) begin
            reg_rdata_q <= {{(`RG_DATA_W-`RG_CAUSE_W){1'b0}}, cause_q}; // R12
        end else if (reg_rd_en) begin
            reg_rdata_q <= {`RG_DATA_W{1'b0}};
        end
    end
end

endmodule

/* rtl/rg_regs.vh */
`ifndef RG_REGS_VH
`define RG_REGS_VH

// ============================================================
// Register map
`define RG_ADDR_W 10
`define RG_DATA_W 16
`define RG_ADDR_CODE_LO 10'h1D0
`define RG_ADDR_CODE_HI 10'h1D1
`define RG_ADDR_CAUSE 10'h1D6

// ============================================================
// Global reset code
`define RG_CODE_LO 16'hF473
`define RG_CODE_HI 16'h57A1
`define RG_CODE_RESET 16'h0000

// ============================================================
// Reset cause fields
`define RG_CAUSE_W 3
`define RG_CAUSE_SOFT 2
`define RG_CAUSE_POR 1
`define RG_CAUSE_PIN 0
`define RG_CAUSE_RESET 3'h0

// ============================================================
// Timing
`define RG_SOFT_CYCLES 3'h7
`define RG_SOFT_CNT_W 3

// ============================================================
// Reset output indices
`define RG_NUM_RST 4
`define RG_RST_CLKMON 0
`define RG_RST_CIPHER 1
`define RG_RST_SPI 2
`define RG_RST_MAIN 3

`endif

/* rtl/rg_rst_sync.v */
`timescale 1ns/1ps
`include "rg_regs.vh"

// ============================================================
// Reset synchroniser: asserts at once, releases after two
// advancing edges once release_ok has been seen high.
module rg_rst_sync (
    input wire clock,
    input wire arst_n,
    input wire advance,
    input wire release_ok,
    output wire rst_n_out
);

reg stage1_q;
reg stage2_q;

always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
        stage1_q <= 1'b0;
        stage2_q <= 1'b0;
    end else if (advance) begin
        // The release permission is held once seen, so a later chip select
        // cannot pull the SPI reset back in during a normal transfer.
        stage1_q <= release_ok || stage1_q; // R4 R17
        stage2_q <= stage1_q; // R17
    end
end

assign rst_n_out = stage2_q;

endmodule

/* rtl/rg_soft_reset.v */
`timescale 1ns/1ps
`include "rg_regs.vh"

// ============================================================
// Global software reset: two code halves and the pulse timer.
module rg_soft_reset (
    input wire clock,
    input wire nrst,
    input wire clear,
    input wire wr_lo,
    input wire wr_hi,
    input wire [`RG_DATA_W-1:0] wdata,
    output wire soft_rst
);

localparam ST_IDLE = 1'b0;
localparam ST_PULSE = 1'b1;

reg state_q;
reg [`RG_DATA_W-1:0] code_lo_q;
reg [`RG_DATA_W-1:0] code_hi_q;
reg [`RG_SOFT_CNT_W-1:0] cnt_q;
reg soft_q;
wire code_match;

// Both halves must hold their exact value together.
assign code_match = (code_lo_q == `RG_CODE_LO) && (code_hi_q == `RG_CODE_HI); // R16 R10

always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        state_q <= ST_IDLE;
        code_lo_q <= `RG_CODE_RESET;
        code_hi_q <= `RG_CODE_RESET;
        cnt_q <= {`RG_SOFT_CNT_W{1'b0}};
        soft_q <= 1'b0;
    end else if (clear) begin
        state_q <= ST_IDLE;
        code_lo_q <= `RG_CODE_RESET;
        code_hi_q <= `RG_CODE_RESET;
        cnt_q <= {`RG_SOFT_CNT_W{1'b0}};
        soft_q <= 1'b0;
    end else begin
        case (state_q)
            ST_IDLE: begin
                if (code_match) begin
                    state_q <= ST_PULSE;
                    soft_q <= 1'b1; // R8
                    cnt_q <= {`RG_SOFT_CNT_W{1'b0}};
                end else begin
                    if (wr_lo) begin
                        code_lo_q <= wdata; // R7
                    end
                    if (wr_hi) begin
                        code_hi_q <= wdata; // R7
                    end
                end
            end
            ST_PULSE: begin
                // Writes are ignored while the pulse runs.
                if (cnt_q == `RG_SOFT_CYCLES) begin
                    state_q <= ST_IDLE;
                    soft_q <= 1'b0; // R9
                    code_lo_q <= `RG_CODE_RESET; // R9
                    code_hi_q <= `RG_CODE_RESET; // R9
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
            default: begin
                state_q <= ST_IDLE;
                soft_q <= 1'b0;
            end
        endcase
    end
end

assign soft_rst = soft_q;

endmodule

/* test/rg_checker_properties.sv */
`timescale 1ns/1ps
`include "rg_regs.vh"
// ============================================================
// Checker on the reset generator ports.
module rg_checker_properties (
    input logic clock,
    input logic nrst,
    input logic reset_pin_n,
    input logic power_on_reset_n,
    input logic clock_missing,
    input logic spi_cs_n,
    input logic reg_wr_en,
    input logic reg_rd_en,
    input logic [`RG_ADDR_W-1:0] reg_addr,
    input logic [`RG_DATA_W-1:0] reg_wdata,
    input logic [`RG_DATA_W-1:0] reg_rdata_q,
    input logic reg_rd_hit_q,
    input logic spi_xfer_error_q,
    input logic clkmon_rst_n,
    input logic cipher_rst_n,
    input logic spi_rst_n,
    input logic main_rst_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_code_lo;
        reg_wr_en && !clock_missing && reg_addr == `RG_ADDR_CODE_LO && reg_wdata == `RG_CODE_LO;
    endsequence
    sequence s_code;
        s_code_lo ##1 reg_wr_en && !clock_missing && reg_addr == `RG_ADDR_CODE_HI && reg_wdata == `RG_CODE_HI;
    endsequence
    a_soft_main_low: assert property (s_code |-> ##[1:2] !main_rst_n [*8])
        else $error("soft reset did not hold main reset");
    a_soft_pulse_end: assert property (s_code |-> ##[11:13] main_rst_n)
        else $error("soft reset pulse too long");
    a_cipher_kept: assert property (s_code |=> cipher_rst_n [*8])
        else $error("cipher reset hit by soft reset");
    a_pin_por_async: assert property (!(reset_pin_n && power_on_reset_n) |-> !clkmon_rst_n && !main_rst_n)
        else $error("pin or por reset not propagated");
    a_cipher_por: assert property (!power_on_reset_n |-> !cipher_rst_n)
        else $error("cipher reset not asserted by por");
    a_spi_clock_lost: assert property (clock_missing |-> !spi_rst_n)
        else $error("spi reset not asserted on clock loss");
    a_spi_release_cs: assert property ($rose(spi_rst_n) |-> $past(spi_cs_n, 2) && $past(reset_pin_n, 2))
        else $error("spi reset released early");
    a_xfer_error: assert property ($fell(spi_cs_n) && clock_missing |-> ##[1:2] spi_xfer_error_q)
        else $error("transfer error not flagged");
    a_cause_hit: assert property (reg_rd_en && reg_addr == `RG_ADDR_CAUSE |=> reg_rd_hit_q)
        else $error("cause read not acknowledged");
    a_unmapped_read: assert property (reg_rd_en && reg_addr != `RG_ADDR_CAUSE |=> reg_rdata_q == 16'h0000 && !reg_rd_hit_q)
        else $error("unmapped read returned data");
endmodule

/* test/rg_host_model.sv */
`timescale 1ns/1ps
// ============================================================
// Host side of the register port; tasks start just after an edge.
module rg_host_model (
    input logic clock,
    input logic [15:0] rdata,
    output logic wr_en,
    output logic rd_en,
    output logic [9:0] addr,
    output logic [15:0] wdata
);
    initial begin
        wr_en = 0;
        rd_en = 0;
        addr = 0;
        wdata = 0;
    end
    // The strobe stays up between writes so back-to-back halves land on adjacent edges.
    task wr(input logic [9:0] a, input logic [15:0] d);
        wr_en = 1;
        addr = a;
        wdata = d;
        @(posedge clock);
        #1;
    endtask
    task idle;
        wr_en = 0;
        wdata = ~wdata;
        @(posedge clock);
        #1;
    endtask
    task rd(input logic [9:0] a, output logic [15:0] d);
        rd_en = 1;
        addr = a;
        @(posedge clock);
        #1;
        d = rdata;
        rd_en = 0;
        @(posedge clock);
        #1;
    endtask
endmodule

/* test/rg_reset_generator_tb_top.sv */
`timescale 1ns/1ps
`include "rg_regs.vh"
module rg_reset_generator_tb_top;
    logic clock = 0, nrst = 0, reset_pin_n = 1, power_on_reset_n = 1, clock_missing = 0, backup_tick = 0;
    logic spi_cs_n = 1, wr_en, rd_en, hit, err, clkmon_n, cipher_n, spi_n, main_n;
    logic [9:0] addr;
    logic [15:0] wdata, rdata, d;
    int bad_count = 0, n_compared = 0, cycles = 0, n;
    always #2 clock = ~clock;
    always @(posedge clock) begin
        #1 backup_tick = (cycles % 4 == 0);
    end
    rg_host_model rg_host_model_i (.clock(clock), .rdata(rdata), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wdata(wdata));
    rg_reset_generator rg_reset_generator_i (.clock(clock), .nrst(nrst), .reset_pin_n(reset_pin_n),
        .power_on_reset_n(power_on_reset_n), .clock_missing(clock_missing), .backup_tick(backup_tick),
        .spi_cs_n(spi_cs_n), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
        .reg_rdata_q(rdata), .reg_rd_hit_q(hit), .spi_xfer_error_q(err), .clkmon_rst_n(clkmon_n),
        .cipher_rst_n(cipher_n), .spi_rst_n(spi_n), .main_rst_n(main_n));
    task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ============================================================
    // Scenarios.
    task t_soft;
        rg_host_model_i.wr(`RG_ADDR_CODE_LO, `RG_CODE_LO);
        rg_host_model_i.wr(`RG_ADDR_CODE_HI, `RG_CODE_HI);
        rg_host_model_i.idle;
        n = 0;
        while (main_n !== 1'b1 && n < 40) begin
            @(posedge clock);
            #1 n++;
        end
        check("soft low cycles", n, 10);
        rg_host_model_i.rd(`RG_ADDR_CAUSE, d);
        check("cause soft", d[2:0], 3'h4);
        rg_host_model_i.rd(`RG_ADDR_CAUSE, d);
        check("cause cleared", d[2:0], 3'h0);
        // Halves were cleared, so one half alone and a wrong other half must not fire.
        rg_host_model_i.wr(`RG_ADDR_CODE_HI, `RG_CODE_HI);
        rg_host_model_i.wr(`RG_ADDR_CODE_LO, 16'hF472);
        rg_host_model_i.idle;
        n = 0;
        repeat (12) begin
            @(posedge clock);
            #1 n = n | !main_n;
        end
        check("no soft reset", n, 16'h0000);
        rg_host_model_i.wr(`RG_ADDR_CODE_LO, `RG_CODE_LO);
        rg_host_model_i.idle;
        repeat (2) @(posedge clock);
        #1 check("soft any order", main_n, 16'h0000);
        repeat (14) @(posedge clock);
        #1 rg_host_model_i.rd(`RG_ADDR_CAUSE, d);
        check("cause soft again", d[2:0], 3'h4);
    endtask
    task t_pin;
        reset_pin_n = 0;
        repeat (3) @(posedge clock);
        #1 check("pin reset", {clkmon_n, cipher_n, spi_n, main_n}, 4'h4);
        reset_pin_n = 1;
        repeat (16) @(posedge clock);
        #1 check("pin release", {clkmon_n, main_n}, 2'h3);
        rg_host_model_i.rd(`RG_ADDR_CAUSE, d);
        check("cause pin", d[2:0], 3'h1);
    endtask
    task t_por;
        power_on_reset_n = 0;
        repeat (3) @(posedge clock);
        #1 check("por cipher", cipher_n, 16'h0000);
        power_on_reset_n = 1;
        repeat (16) @(posedge clock);
        #1 check("por released", cipher_n, 16'h0001);
        rg_host_model_i.rd(`RG_ADDR_CAUSE, d);
        check("cause por", d[2:1], 2'h1);
        rg_host_model_i.rd(10'h1D2, d);
        check("unmapped", d, 0);
    endtask
    task t_miss;
        clock_missing = 1;
        @(posedge clock);
        #1 spi_cs_n = 0;
        n = 0;
        repeat (3) begin
            @(posedge clock);
            #1 n = n | err;
        end
        check("xfer error", n, 1);
        clock_missing = 0;
        repeat (4) @(posedge clock);
        #1 check("spi held by cs", spi_n, 16'h0000);
        spi_cs_n = 1;
        repeat (4) @(posedge clock);
        #1 check("spi released", spi_n, 16'h0001);
        spi_cs_n = 0;
        repeat (4) @(posedge clock);
        #1 check("spi kept in transfer", spi_n, 16'h0001);
        spi_cs_n = 1;
        repeat (2) @(posedge clock);
        #1;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            print_verdict;
        end
    end
    initial begin
        repeat (5) @(posedge clock);
        #1 nrst = 1;
        repeat (4) @(posedge clock);
        #1 t_soft;
        t_pin;
        t_por;
        t_miss;
        print_verdict;
    end
endmodule
bind rg_reset_generator rg_checker_properties rg_checker_properties_i (.clock(clock), .nrst(nrst),
    .reset_pin_n(reset_pin_n), .power_on_reset_n(power_on_reset_n), .clock_missing(clock_missing),
    .spi_cs_n(spi_cs_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rd_hit_q(reg_rd_hit_q),
    .spi_xfer_error_q(spi_xfer_error_q), .clkmon_rst_n(clkmon_rst_n), .cipher_rst_n(cipher_rst_n),
    .spi_rst_n(spi_rst_n), .main_rst_n(main_rst_n));
